// *** core/secfe_pkg.sv ***
// Shared constants and types for the serial EEPROM command front end.
// Assumes one system clock samples every pin of the serial link.
package secfe_pkg;

   // ---------------------------------------------------------------
   // Opcodes, one byte each, sent MSB first
   // ---------------------------------------------------------------
   localparam logic [7:0] SET_WRITE_LATCH_CMD   = 8'h06;
   localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
   localparam logic [7:0] STATUS_READ_CMD       = 8'h05;
   localparam logic [7:0] STATUS_WRITE_CMD      = 8'h01;
   localparam logic [7:0] ARRAY_READ_CMD        = 8'h03;
   localparam logic [7:0] ARRAY_WRITE_CMD       = 8'h02;
   localparam logic [7:0] ID_READ_CMD           = 8'h83;
   localparam logic [7:0] ID_WRITE_CMD          = 8'h82;

   // ---------------------------------------------------------------
   // Field positions, bounds and reset values
   // ---------------------------------------------------------------
   localparam int          ADDR_W          = 16;
   localparam logic [0:0]  ADDR_LAST_BYTE  = 1'h1;
   localparam int          ADDRESS_BIT_TEN = 10;
   localparam int          ST_LOCK_POS     = 7;
   localparam int          ST_BP_HIGH_POS  = 3;
   localparam int          ST_BP_LOW_POS   = 2;
   localparam int          ST_LATCH_POS    = 1;
   localparam int          ST_BUSY_POS     = 0;
   localparam logic [14:0] QUARTER_BASE    = 15'h6000;
   localparam logic [14:0] HALF_BASE       = 15'h4000;
   // Pin order: chip select, clock, data in, hold, write protect;
   // select resets low so only a really sampled high arms the device
   localparam logic [4:0]  PIN_IDLE        = 5'h03;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_OPCODE = 3'h1,
      ST_ADDR   = 3'h3,
      ST_XFER   = 3'h2,
      ST_WAIT   = 3'h6,
      ST_IGNORE = 3'h7
   } secfe_state_t;

   typedef enum logic [3:0] {
      CMD_NONE, CMD_SETL, CMD_CLRL, CMD_SREAD, CMD_SWRITE,
      CMD_AREAD, CMD_AWRITE, CMD_IDREAD, CMD_IDWRITE
   } secfe_cmd_t;

   typedef enum logic [1:0] {
      KIND_ARRAY, KIND_ID_PAGE, KIND_ID_LOCK
   } secfe_kind_t;

   typedef struct packed {
      logic statusLock;
      logic blockProtectHigh;
      logic blockProtectLow;
   } secfe_nv_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0]        data;
      logic              idPage;
   } secfe_wr_t;

   // Block-protect map over the 32K array
   function automatic logic secfe_prot_hit(input secfe_nv_t nv,
                                           input logic [14:0] a);
      logic hit;
      hit = 1'b0;
      unique case ({nv.blockProtectHigh, nv.blockProtectLow})
         2'h0: hit = 1'b0;
         2'h1: hit = (a >= QUARTER_BASE);
         2'h2: hit = (a >= HALF_BASE);
         2'h3: hit = 1'b1;
      endcase
      return hit;
   endfunction : secfe_prot_hit

endpackage : secfe_pkg

// *** core/secfe_front_end.sv ***
// Serial slave front end of a byte-wide EEPROM: pin sampling, framing,
// hold, opcode decode, write latch, protection and execution checks.
// Assumes array, id page and non-volatile status storage sit outside and
// report completion of a self-timed write with cycleDone.
//
// Operation
// - Data out changes only after serial clock falling edges.
// - Data in is sampled on each serial clock rising edge.
// - Chip select high deselects; data out floats.
// - After power-up, select needs chip select high then falling.
// - During hold, data out floats and clock and data are ignored.
// - Hold starts and ends on hold edges while clock is low.
// - Bit count and position are kept across a hold.
// - Chip select rising during hold abandons the instruction.
// - Reset: deselected, write latch and busy clear, protect bits kept.
// - Writes need a clock count that is a multiple of eight.
// - Data-modifying instructions need the write latch set first.
// - Write latch clears at power-up, write-disable and write completion.
// - Execute only if select rises right after the last bit's edge.
// - Block-protect bits map protected array address ranges.
// - Write protect pin guards the block-protect bits with lock bit.
// - Unknown opcode: ignore rest of transfer until reselected.
// - Opcodes: set latch 06h, clear latch 04h, status write 01h.
// - Opcodes: status read 05h, array read 03h, array write 02h.
// - Opcode 83h reads id page, or lock status when bit ten set.
// - Opcode 82h writes id page, or locks it when bit ten set.
// - Busy flag reads one while a write cycle runs.
// - Lock bit with write protect low blocks status writes.
`timescale 1ns/1ps
module secfe_front_end
   import secfe_pkg::*;
#(
   parameter bit ID_PAGE_EN = 1'b1
) (
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic              csN,
   input  wire logic              sclk,
   input  wire logic              mosi,
   input  wire logic              holdN,
   input  wire logic              wpN,
   output logic                   misoOut,
   output logic                   misoOe,
   input  wire secfe_nv_t         nvStatus,
   output logic                   nvWriteStb,
   output secfe_nv_t              nvWriteData,
   output logic                   memRdReq,
   output logic [ADDR_W-1:0]      memRdAddr,
   output logic                   memRdIdPage,
   input  wire logic [7:0]        memRdData,
   output logic                   wrByteStb,
   output secfe_wr_t              wrByte,
   output logic                   wrCommit,
   output secfe_kind_t            wrCommitKind,
   output logic                   wrAbort,
   input  wire logic              cycleDone,
   input  wire logic              idLocked,
   output logic                   writeBusy,
   output logic                   writeLatch,
   output logic                   hardwareLocked,
   output logic                   selected
);

   // ---------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ---------------------------------------------------------------
   logic [4:0]        pinMeta_q, pinSync_q;
   logic              csS, sclkS, mosiS, holdS, wpS;
   logic              sclkPrev_q, csPrev_q;
   logic              sclkRise, sclkFall, csFall, csRise;
   logic              armed_q, selected_q, holdActive_q;
   secfe_state_t      state_q, decState;
   secfe_cmd_t        cmd_q, decCmd;
   logic [2:0]        bitCnt_q;
   logic [7:0]        shift_q, nextShift, rdByte_q, srcByte, statusByte;
   logic [6:0]        outShift_q;
   logic [0:0]        addrCnt_q;
   logic [ADDR_W-1:0] addr_q, startAddr_q;
   logic              dataSeen_q, rdPend_q, wel_q, busy_q;
   logic              byteDone, isRead, isPageWrite, lockRead;
   logic              execOk, startOk, protHit, idAlt;

   // Both flops of each pin stay together; only the second is read
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pinMeta_q <= PIN_IDLE;
         pinSync_q <= PIN_IDLE;
      end else begin
         pinMeta_q <= {csN, sclk, mosi, holdN, wpN};
         pinSync_q <= pinMeta_q;
      end
   end

   assign {csS, sclkS, mosiS, holdS, wpS} = pinSync_q;

   // Previous levels for edge finding
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sclkPrev_q <= 1'b0;
         csPrev_q   <= 1'b0;
      end else begin
         sclkPrev_q <= sclkS;
         csPrev_q   <= csS;
      end
   end

   // Clock edges vanish while paused
   assign sclkRise = sclkS & ~sclkPrev_q & ~holdActive_q;
   assign sclkFall = ~sclkS & sclkPrev_q & ~holdActive_q;
   assign csFall   = ~csS & csPrev_q;
   assign csRise   = csS & ~csPrev_q;

   // ---------------------------------------------------------------
   // Framing: arming, selection, hold
   // ---------------------------------------------------------------
   // A select held low through power-up must not start a command
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         armed_q    <= 1'b0;
         selected_q <= 1'b0;
      end else begin
         if (csS)
            armed_q <= 1'b1;
         if (csS)
            selected_q <= 1'b0;
         else if (csFall && armed_q)
            selected_q <= 1'b1;
      end
   end

   // Hold follows the hold pin only while the clock sits low
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         holdActive_q <= 1'b0;
      else if (csS)
         holdActive_q <= 1'b0;
      else if (selected_q && !sclkS)
         holdActive_q <= ~holdS;
   end

   // ---------------------------------------------------------------
   // Opcode decode
   // ---------------------------------------------------------------
   assign nextShift = {shift_q[6:0], mosiS};
   assign byteDone  = (bitCnt_q == 3'h7);

   always_comb begin
      unique case (nextShift)
         SET_WRITE_LATCH_CMD:   decCmd = CMD_SETL;
         CLEAR_WRITE_LATCH_CMD: decCmd = CMD_CLRL;
         STATUS_WRITE_CMD:      decCmd = CMD_SWRITE;
         STATUS_READ_CMD:       decCmd = CMD_SREAD;
         ARRAY_READ_CMD:        decCmd = CMD_AREAD;
         ARRAY_WRITE_CMD:       decCmd = CMD_AWRITE;
         ID_READ_CMD:   decCmd = ID_PAGE_EN ? CMD_IDREAD : CMD_NONE;
         ID_WRITE_CMD:  decCmd = ID_PAGE_EN ? CMD_IDWRITE : CMD_NONE;
         default:               decCmd = CMD_NONE;
      endcase
      // Only status reads are served while a write cycle runs
      if (busy_q && decCmd != CMD_SREAD)
         decState = ST_IGNORE;
      else begin
         unique case (decCmd)
            CMD_NONE:              decState = ST_IGNORE;
            CMD_SETL, CMD_CLRL:    decState = ST_WAIT;
            CMD_SREAD, CMD_SWRITE: decState = ST_XFER;
            default:               decState = ST_ADDR;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Sequencer: bit count, shift register, state
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q    <= ST_IDLE;
         cmd_q      <= CMD_NONE;
         bitCnt_q   <= 3'h0;
         shift_q    <= 8'h00;
         addrCnt_q  <= 1'h0;
         dataSeen_q <= 1'b0;
      end else if (csFall && armed_q) begin
         state_q    <= ST_OPCODE;
         cmd_q      <= CMD_NONE;
         bitCnt_q   <= 3'h0;
         addrCnt_q  <= 1'h0;
         dataSeen_q <= 1'b0;
      end else if (csS) begin
         state_q <= ST_IDLE;
      end else if (sclkRise && selected_q) begin
         bitCnt_q <= bitCnt_q + 3'h1;
         shift_q  <= nextShift;
         unique case (state_q)
            ST_OPCODE: if (byteDone) begin
               cmd_q   <= decCmd;
               state_q <= decState;
            end
            ST_ADDR: if (byteDone) begin
               addrCnt_q <= addrCnt_q + 1'h1;
               if (addrCnt_q == ADDR_LAST_BYTE)
                  state_q <= ST_XFER;
            end
            ST_XFER: if (byteDone && (cmd_q == CMD_SWRITE || isPageWrite))
            begin
               dataSeen_q <= 1'b1;
               if (cmd_q == CMD_SWRITE)
                  state_q <= ST_WAIT;
            end
            // A clock past the last bit spoils the instruction
            ST_WAIT: state_q <= ST_IGNORE;
            ST_IDLE, ST_IGNORE: state_q <= state_q;
         endcase
      end
   end

   assign isRead      = (cmd_q == CMD_SREAD) || (cmd_q == CMD_AREAD) ||
                        (cmd_q == CMD_IDREAD);
   assign isPageWrite = (cmd_q == CMD_AWRITE) || (cmd_q == CMD_IDWRITE);
   assign idAlt       = addr_q[ADDRESS_BIT_TEN];
   assign lockRead    = (cmd_q == CMD_IDREAD) && idAlt;

   // ---------------------------------------------------------------
   // Address, read fetch and streamed write bytes
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_q      <= '0;
         startAddr_q <= '0;
         memRdReq    <= 1'b0;
         memRdAddr   <= '0;
         memRdIdPage <= 1'b0;
         wrByteStb   <= 1'b0;
         wrByte      <= '0;
      end else begin
         memRdReq  <= 1'b0;
         wrByteStb <= 1'b0;
         if (sclkRise && selected_q && !csS && byteDone) begin
            if (state_q == ST_ADDR) begin
               addr_q <= {addr_q[7:0], nextShift};
               if (addrCnt_q == ADDR_LAST_BYTE) begin
                  startAddr_q <= {addr_q[7:0], nextShift};
                  memRdAddr   <= {addr_q[7:0], nextShift};
                  memRdIdPage <= (cmd_q == CMD_IDREAD);
                  // Bit ten sits in the high byte, now in addr_q[7:0]
                  memRdReq    <= (cmd_q == CMD_AREAD) ||
                     ((cmd_q == CMD_IDREAD) &&
                      !addr_q[ADDRESS_BIT_TEN - 8]);
               end
            end else if (state_q == ST_XFER && isPageWrite) begin
               wrByteStb     <= 1'b1;
               wrByte.addr   <= addr_q;
               wrByte.data   <= nextShift;
               wrByte.idPage <= (cmd_q == CMD_IDWRITE);
               addr_q        <= addr_q + 16'h0001;
            end
         end
         // Prefetch the next byte as the current one starts out
         if (sclkFall && state_q == ST_XFER && bitCnt_q == 3'h0 &&
             (cmd_q == CMD_AREAD || (cmd_q == CMD_IDREAD && !idAlt))) begin
            addr_q    <= addr_q + 16'h0001;
            memRdAddr <= addr_q + 16'h0001;
            memRdReq  <= 1'b1;
         end
      end
   end

   // Fetched data arrives one cycle after the request
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdPend_q <= 1'b0;
         rdByte_q <= 8'h00;
      end else begin
         rdPend_q <= memRdReq;
         if (rdPend_q)
            rdByte_q <= memRdData;
      end
   end

   // ---------------------------------------------------------------
   // Serial output
   // ---------------------------------------------------------------
   always_comb begin
      statusByte                 = 8'h00;
      statusByte[ST_LOCK_POS]    = nvStatus.statusLock;
      statusByte[ST_BP_HIGH_POS] = nvStatus.blockProtectHigh;
      statusByte[ST_BP_LOW_POS]  = nvStatus.blockProtectLow;
      statusByte[ST_LATCH_POS]   = wel_q;
      statusByte[ST_BUSY_POS]    = busy_q;
      if (cmd_q == CMD_SREAD)
         srcByte = statusByte;
      else if (lockRead)
         srcByte = {7'h00, idLocked};
      else
         srcByte = rdByte_q;
   end

   // New byte loads at a byte boundary; a status read repeats forever
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         misoOut    <= 1'b0;
         outShift_q <= 7'h00;
      end else if (sclkFall && state_q == ST_XFER && isRead) begin
         if (bitCnt_q == 3'h0) begin
            misoOut    <= srcByte[7];
            outShift_q <= srcByte[6:0];
         end else begin
            misoOut    <= outShift_q[6];
            outShift_q <= {outShift_q[5:0], 1'b0};
         end
      end
   end

   assign misoOe = selected_q && !csS && !holdActive_q &&
                   state_q == ST_XFER && isRead;

   // ---------------------------------------------------------------
   // Execution on deselect
   // ---------------------------------------------------------------
   assign hardwareLocked = nvStatus.statusLock && !wpS;
   assign protHit = secfe_prot_hit(nvStatus, startAddr_q[14:0]);

   // Last bit's rising edge must be the final clock before select rises
   assign execOk = csRise && selected_q && !holdActive_q &&
                   (state_q == ST_WAIT ||
                    (state_q == ST_XFER && isPageWrite &&
                     bitCnt_q == 3'h0 && dataSeen_q));
   assign startOk = execOk && wel_q &&
      ((cmd_q == CMD_SWRITE && !hardwareLocked) ||
       (cmd_q == CMD_AWRITE && !protHit) ||
       (cmd_q == CMD_IDWRITE && !idLocked));

   // Latch clears on write-disable or when the accepted write cycle finishes
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wel_q  <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         if (busy_q && cycleDone)
            wel_q <= 1'b0;
         else if (execOk && cmd_q == CMD_SETL)
            wel_q <= 1'b1;
         else if (execOk && cmd_q == CMD_CLRL)
            wel_q <= 1'b0;
         if (startOk)
            busy_q <= 1'b1;
         else if (cycleDone)
            busy_q <= 1'b0;
      end
   end

   // Start strobes to the storage side
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         nvWriteStb   <= 1'b0;
         nvWriteData  <= '0;
         wrCommit     <= 1'b0;
         wrCommitKind <= KIND_ARRAY;
         wrAbort      <= 1'b0;
      end else begin
         nvWriteStb <= startOk && cmd_q == CMD_SWRITE;
         nvWriteData <= {shift_q[ST_LOCK_POS], shift_q[ST_BP_HIGH_POS],
                         shift_q[ST_BP_LOW_POS]};
         wrCommit <= startOk && isPageWrite;
         wrAbort  <= csRise && selected_q && isPageWrite && !startOk;
         if (cmd_q == CMD_AWRITE)
            wrCommitKind <= KIND_ARRAY;
         else
            wrCommitKind <= idAlt ? KIND_ID_LOCK : KIND_ID_PAGE;
      end
   end

   assign writeBusy  = busy_q;
   assign writeLatch = wel_q;
   assign selected   = selected_q;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence s_cs_rise_in_hold;
      csRise && holdActive_q;
   endsequence
   sequence s_no_start;
      !nvWriteStb && !wrCommit;
   endsequence

   property p_out_after_fall;
      $changed(misoOut) |-> $past(sclkFall);
   endproperty
   a_out_after_fall: assert property (p_out_after_fall)
      else $error("data out changed without a clock fall");
   property p_float_deselect;
      $past(csS) |-> !misoOe;
   endproperty
   a_float_deselect: assert property (p_float_deselect)
      else $error("data out driven while deselected");
   property p_select_armed;
      $rose(selected_q) |-> $past(csFall) && $past(armed_q);
   endproperty
   a_select_armed: assert property (p_select_armed)
      else $error("selected without an armed falling edge");
   property p_hold_freeze;
      holdActive_q && !csS |=> $stable(bitCnt_q) || !holdActive_q;
   endproperty
   a_hold_freeze: assert property (p_hold_freeze)
      else $error("bit count moved during hold");
   property p_hold_abandon;
      s_cs_rise_in_hold |=> s_no_start;
   endproperty
   a_hold_abandon: assert property (p_hold_abandon)
      else $error("instruction ran after deselect in hold");
   property p_latch_needed;
      (nvWriteStb || wrCommit) |-> $past(wel_q, 1);
   endproperty
   a_latch_needed: assert property (p_latch_needed)
      else $error("write started without write latch");
   property p_latch_clear;
      busy_q && cycleDone |=> !wel_q && !busy_q;
   endproperty
   a_latch_clear: assert property (p_latch_clear)
      else $error("latch or busy not cleared at completion");
   property p_protect;
      wrCommit && wrCommitKind == KIND_ARRAY |-> !protHit;
   endproperty
   a_protect: assert property (p_protect)
      else $error("write committed into protected block");
   property p_hw_lock;
      nvWriteStb |-> !$past(hardwareLocked);
   endproperty
   a_hw_lock: assert property (p_hw_lock)
      else $error("status write while hardware locked");
   property p_ignore_quiet;
      state_q == ST_IGNORE |-> !misoOe ##1 (!misoOe || csFall);
   endproperty
   a_ignore_quiet: assert property (p_ignore_quiet)
      else $error("data out driven after unknown opcode");

endmodule : secfe_front_end

// *** verification/secfe_master_model.sv ***
// Master model: mode 0 frames, MSB first, optional hold pause.
// Assumes ref_clk samples the pins; one bit takes 8 cycles (400 ns).
`timescale 1ns/1ps
module secfe_master_model (
   input  wire logic ref_clk,
   input  wire logic misoOut,
   input  wire logic misoOe,
   output logic      csN,
   output logic      sclk,
   output logic      mosi,
   output logic      holdN,
   output logic      oeHold
);
   // ----
   // Frame driver
   // ----
   // Select starts low, so the first frame has no falling edge
   initial begin
      csN    = 1'b0;
      sclk   = 1'b0;
      mosi   = 1'b0;
      holdN  = 1'b1;
      oeHold = 1'b1;
   end
   // Sends n bits of d; a pause before bit hb toggles the clock inside it;
   // hb equal to n pauses over the deselect instead
   task automatic xf(input logic [31:0] d, input int n, input int hb,
                     output logic [7:0] rx);
      rx = 8'h00;
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge ref_clk);
         csN  <= 1'b0;
         mosi <= d[i];
         if (i == hb) begin
            holdN <= 1'b0;
            repeat (4) @(posedge ref_clk);
            sclk <= 1'b1;
            repeat (4) @(posedge ref_clk);
            sclk <= 1'b0;
            repeat (4) @(posedge ref_clk);
            oeHold <= misoOe;
            holdN  <= 1'b1;
            repeat (4) @(posedge ref_clk);
         end
         repeat (3) @(posedge ref_clk);
         rx   = {rx[6:0], misoOe ? misoOut : 1'bx};
         sclk <= 1'b1;
         repeat (4) @(posedge ref_clk);
         sclk <= 1'b0;
      end
      if (hb == n) begin
         holdN <= 1'b0;
         repeat (4) @(posedge ref_clk);
      end
      csN   <= 1'b1;
      holdN <= 1'b1;
      repeat (6) @(posedge ref_clk);
   endtask : xf
endmodule : secfe_master_model

// *** verification/secfe_front_end_tb.sv ***
// Testbench: master model on the pins, storage stub on the array side.
// Assumes 20 MHz ref_clk; status bits live in the stub.
`timescale 1ns/1ps
module secfe_front_end_tb;
   import secfe_pkg::*;
   logic        ref_clk, rst_n, wpN, oeHold, p;
   logic        cycleDone = 1'b0;
   logic        idLocked  = 1'b0;
   logic        csN, sclk, mosi, holdN, misoOut, misoOe, nvWriteStb;
   logic        memRdReq, memRdIdPage, wrCommit, lastId, selected;
   logic        writeBusy, writeLatch, hardwareLocked;
   logic [7:0]  rx;
   logic [7:0]  memRdData = 8'h00;
   logic [7:0]  busyCnt   = 8'h00;
   logic [15:0] memRdAddr, k;
   logic [15:0] nCommit   = 16'h0000;
   secfe_nv_t   nvWriteData;
   secfe_nv_t   nvStatus  = '0;
   secfe_kind_t wrCommitKind, lastKind;
   int          nMismatch = 0;
   int          testsRun = 0;
   logic [15:0] al [6] = '{16'h0000, 16'h3FFF, 16'h4000, 16'h5FFF,
                           16'h6000, 16'h7FFF};
   // ----
   // Harness
   // ----
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   secfe_front_end secfe_front_end_inst (.ref_clk, .rst_n, .csN, .sclk,
      .mosi, .holdN, .wpN, .misoOut, .misoOe, .nvStatus, .nvWriteStb,
      .nvWriteData, .memRdReq, .memRdAddr, .memRdIdPage, .memRdData,
      .wrByteStb(), .wrByte(), .wrCommit, .wrCommitKind, .wrAbort(),
      .cycleDone, .idLocked, .writeBusy, .writeLatch, .hardwareLocked,
      .selected);
   secfe_master_model secfe_master_model_inst (.ref_clk, .misoOut,
      .misoOe, .csN, .sclk, .mosi, .holdN, .oeHold);
   // Storage stub; a short self-timed cycle keeps the run brief
   always @(posedge ref_clk) begin
      memRdData <= memRdAddr[7:0] ^ 8'hA5;
      busyCnt   <= writeBusy ? busyCnt + 8'h01 : 8'h00;
      cycleDone <= (busyCnt == 8'hC8);
      if (nvWriteStb) nvStatus <= nvWriteData;
      if (memRdReq) lastId <= memRdIdPage;
      if (wrCommit) begin
         nCommit  <= nCommit + 16'h0001;
         lastKind <= wrCommitKind;
         idLocked <= idLocked | (wrCommitKind == KIND_ID_LOCK);
      end
   end
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      testsRun++;
      if (g !== e) begin
         nMismatch++;
         $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic giveVerdict();
      if (nMismatch == 0 && testsRun > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : giveVerdict
   // Bounded wait for the self-timed cycle to end
   task automatic wt();
      for (int j = 0; j < 400 && writeBusy !== 1'b0; j++) @(posedge ref_clk);
      chk(writeBusy, 1'b0);
   endtask : wt
   task automatic wstat(input logic [7:0] v);
      secfe_master_model_inst.xf(SET_WRITE_LATCH_CMD, 8, -1, rx);
      secfe_master_model_inst.xf({STATUS_WRITE_CMD, v}, 16, -1, rx);
   endtask : wstat
   initial begin
      rst_n     = 1'b0;
      wpN       = 1'b1;
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      chk({writeLatch, writeBusy, selected, misoOe}, 16'h0000);
      secfe_master_model_inst.xf(SET_WRITE_LATCH_CMD, 8, -1, rx);
      chk(writeLatch, 1'b0);
      secfe_master_model_inst.xf(SET_WRITE_LATCH_CMD, 8, -1, rx);
      chk(writeLatch, 1'b1);
      secfe_master_model_inst.xf({STATUS_READ_CMD, 8'h00}, 16, -1, rx);
      chk(rx, 8'h02);
      secfe_master_model_inst.xf({STATUS_READ_CMD, 8'h00}, 16, 5, rx);
      chk({oeHold, rx}, 9'h002);
      secfe_master_model_inst.xf(CLEAR_WRITE_LATCH_CMD, 8, -1, rx);
      chk(writeLatch, 1'b0);
      secfe_master_model_inst.xf({SET_WRITE_LATCH_CMD, 1'b0}, 9, -1, rx);
      chk(writeLatch, 1'b0);
      secfe_master_model_inst.xf({8'hFF, SET_WRITE_LATCH_CMD}, 16, -1, rx);
      chk(writeLatch, 1'b0);
      secfe_master_model_inst.xf({STATUS_WRITE_CMD, 8'h8C}, 16, -1, rx);
      chk({writeBusy, nvStatus}, 4'h0);
      secfe_master_model_inst.xf(SET_WRITE_LATCH_CMD, 8, -1, rx);
      secfe_master_model_inst.xf({STATUS_WRITE_CMD, 7'h46}, 15, -1, rx);
      chk({writeBusy, writeLatch, nvStatus}, 5'h08);
      secfe_master_model_inst.xf({STATUS_WRITE_CMD, 8'h8C}, 16, 16, rx);
      chk({writeBusy, writeLatch, nvStatus}, 5'h08);
      wstat(8'h8C);
      secfe_master_model_inst.xf({STATUS_READ_CMD, 8'h00}, 16, -1, rx);
      chk(rx, 8'h8F);
      wt();
      chk({writeLatch, nvStatus}, 4'h7);
      wpN <= 1'b0;
      wstat(8'h00);
      chk({hardwareLocked, writeBusy, nvStatus}, 5'h17);
      wpN <= 1'b1;
      wstat(8'h00);
      wt();
      chk({hardwareLocked, nvStatus}, 4'h0);
      // Every protect setting against both edges of each protected range
      for (int b = 0; b < 4; b++) begin
         wstat({4'h0, 2'(b), 2'h0});
         wt();
         foreach (al[i]) begin
            k = nCommit;
            p = b == 3 || (b == 2 && al[i] >= 16'h4000)
                || (b == 1 && al[i] >= 16'h6000);
            secfe_master_model_inst.xf(SET_WRITE_LATCH_CMD, 8, -1, rx);
            secfe_master_model_inst.xf({ARRAY_WRITE_CMD, al[i], 8'h55},
                                       32, -1, rx);
            wt();
            chk(nCommit - k, {15'h0000, !p});
         end
      end
      secfe_master_model_inst.xf(SET_WRITE_LATCH_CMD, 8, -1, rx);
      secfe_master_model_inst.xf({ID_WRITE_CMD, 16'h0400, 8'h00}, 32, -1, rx);
      wt();
      chk({idLocked, lastKind}, {1'b1, KIND_ID_LOCK});
      secfe_master_model_inst.xf({ID_READ_CMD, 16'h0400, 8'h00}, 32, -1, rx);
      chk(rx, 8'h01);
      secfe_master_model_inst.xf({ID_READ_CMD, 16'h0000, 8'h00}, 32, -1, rx);
      chk(lastId, 1'b1);
      secfe_master_model_inst.xf({ARRAY_READ_CMD, 16'h0012, 8'h00}, 32, -1,
                                 rx);
      chk({lastId, rx}, 9'h0B7);
      giveVerdict();
   end
   // Watchdog: the sequence needs about 15500 cycles
   initial begin
      repeat (60000) @(posedge ref_clk);
      nMismatch++;
      giveVerdict();
   end
endmodule : secfe_front_end_tb
